// ---- verilog/aux_clk_consts.svh ----
// register offsets, field positions, reset values and timing figures of the
// auxiliary clock-output / converter controller; definitions only
`ifndef AUX_CLK_CONSTS_SVH
`define AUX_CLK_CONSTS_SVH

// register indices (the bus address is compared with the index itself, unscaled)
`define REG_OCLK      8'h0a
`define REG_ADCCFG    8'h0f
`define REG_SOFFS     8'h10
`define REG_RESULT    8'h11
`define REG_TSCTL     8'h12
`define REG_TVOFFS    8'h13
`define REG_STATUS    8'h20
`define REG_MASK      8'h21

// reset values
`define RST_OCLK      8'h06
`define RST_ADCCFG    8'h00
`define RST_SOFFS     8'h00
`define RST_TSCTL     8'h20
`define RST_TVOFFS    8'h00
`define RST_RESULT    8'h00
`define RST_MASK      8'h00

// output clock control fields
`define OCLK_SEL      2:0
`define OCLK_ENLF     3
`define OCLK_TAIL     5:4
`define OCLK_USED     8'h3f
`define SEL_LF        3'h7

// converter configuration fields
`define ADC_START     7
`define ADC_INSEL     6:4
`define ADC_REF       3:2
`define ADC_GAIN      1:0
`define INSEL_TEMP    3'h0
`define SOFFS_USED    8'h0f

// temperature sensor control fields
`define TS_RANGE      7:6
`define TS_OFFS_EN    5
`define TS_TRIM_EN    4
`define TS_TRIM       3:2
`define TS_BG_TRIM    1:0

// status / mask bits
`define ST_ADC_DONE   0
`define ST_CLK_STOP   1
`define ST_USED       8'h03

// output clock periods in crystal half cycles (30, 15, 10, 4, 3, 2, 1 MHz)
`define HALF_30M      6'h02
`define HALF_15M      6'h04
`define HALF_10M      6'h06
`define HALF_4M       6'h0f
`define HALF_3M       6'h14
`define HALF_2M       6'h1e
`define HALF_1M       6'h3c
// low-frequency clock: one period is two low-frequency edges
`define HALF_LF       6'h02

// clock tail lengths in output clock cycles
`define TAIL_0        10'h000
`define TAIL_1        10'h080
`define TAIL_2        10'h100
`define TAIL_3        10'h200

// timing
`define CLK_PERIOD_NS 8
`define ADC_CONV_NS   350000

`endif

// ---- verilog/aux_clk_pkg.sv ----
// types shared by the auxiliary clock-output / converter controller
// assumes aux_clk_consts.svh is compiled alongside
package aux_clk_pkg;

    typedef enum logic [2:0] {
        CG_RUN  = 3'b001,
        CG_TAIL = 3'b010,
        CG_OFF  = 3'b100
    } cg_state_e;

    // output clock generator state
    typedef struct packed {
        cg_state_e  st;
        logic [5:0] pos;
        logic [9:0] tail;
        logic [2:0] sel;
        logic       lf;
        logic       clk;
        logic       xen;
        logic       stop_p;
    } cg_state_s;

    // controller state
    typedef struct packed {
        logic [7:0]  oclk;
        logic [6:0]  adccfg;
        logic [7:0]  soffs;
        logic [7:0]  tsctl;
        logic [7:0]  tvoffs;
        logic [7:0]  result;
        logic [7:0]  status;
        logic [7:0]  mask;
        logic        done;
        logic        busy;
        logic [19:0] conv_cnt;
        logic        wreq;
        logic [31:0] rdata;
        logic        irq;
        logic        por;
        logic        por_n;
        logic        spwr;
    } ctrl_state_s;

    // settings handed to the analog converter and sensor
    typedef struct packed {
        logic [2:0] input_sel;
        logic [1:0] ref_sel;
        logic [1:0] gain;
        logic [3:0] sensor_offset;
        logic [1:0] temp_range;
        logic       temp_offs_en;
        logic       temp_trim_en;
        logic [1:0] temp_trim;
        logic [1:0] bg_trim;
        logic       sensor_power;
    } analog_ctrl_s;

endpackage : aux_clk_pkg

// ---- verilog/clkout_gen.sv ----
// glitch-free output clock generator: crystal division, low-frequency
// substitute in sleep, clock tail, stop and restart on period boundaries
// assumes crystal and low-frequency edge pulses synchronous to clock
`timescale 1ns/100ps
`include "aux_clk_consts.svh"

module clkout_gen (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       xtal_edge,
    input  wire logic       lf_edge,
    input  wire logic [2:0] sel,
    input  wire logic       enlfc,
    input  wire logic [1:0] tail_code,
    input  wire logic       sleep_eff,
    output logic            clk_out,
    output logic            xtal_enable,
    output logic            stop_pulse
);

    aux_clk_pkg::cg_state_s s, n;

    function automatic logic [5:0] half_of(input logic lf, input logic [2:0] code);
        logic [5:0] h;
        h = `HALF_LF;
        if (!lf) begin
            unique case (code)
                3'h0:    h = `HALF_30M;
                3'h1:    h = `HALF_15M;
                3'h2:    h = `HALF_10M;
                3'h3:    h = `HALF_4M;
                3'h4:    h = `HALF_3M;
                3'h5:    h = `HALF_2M;
                3'h6:    h = `HALF_1M;
                default: h = `HALF_LF;
            endcase
        end
        return h;
    endfunction : half_of

    function automatic logic [9:0] tail_len(input logic [1:0] code);
        logic [9:0] t;
        unique case (code)
            2'h0: t = `TAIL_0;
            2'h1: t = `TAIL_1;
            2'h2: t = `TAIL_2;
            2'h3: t = `TAIL_3;
        endcase
        return t;
    endfunction : tail_len

    logic       tick;
    logic       want_lf;
    logic       stop_req;
    logic [5:0] period;
    logic [5:0] high;

    always_comb begin
        n        = s;
        n.stop_p = 1'b0;
        tick     = s.lf ? lf_edge : xtal_edge;
        // (RL5) sleep with substitute on uses low-frequency clock
        want_lf  = sleep_eff & enlfc;
        stop_req = sleep_eff & ~enlfc;
        period   = half_of(s.lf, s.sel);
        high     = (period + 6'h01) >> 1;
        unique case (s.st)
            aux_clk_pkg::CG_OFF: begin
                // (RL19) restart aligned to a source edge, from low
                if (!stop_req && (want_lf ? lf_edge : xtal_edge)) begin
                    n.st  = aux_clk_pkg::CG_RUN;
                    n.sel = (want_lf || sel == `SEL_LF) ? `SEL_LF : sel;
                    n.lf  = want_lf || sel == `SEL_LF;
                    n.pos = 6'h00;
                    n.clk = 1'b1;
                end
            end
            aux_clk_pkg::CG_RUN, aux_clk_pkg::CG_TAIL: begin
                if (tick) begin
                    if (s.pos == period - 6'h01) begin
                        // (RL19) every change waits for a period boundary
                        n.pos = 6'h00;
                        n.clk = 1'b1;
                        if (stop_req && s.st == aux_clk_pkg::CG_TAIL && s.tail > 10'h001) begin
                            n.tail = s.tail - 10'h001;
                        end else if (stop_req && (s.st == aux_clk_pkg::CG_TAIL
                                                  || tail_len(tail_code) == `TAIL_0)) begin
                            // (RL6) tail spent: stop low
                            n.st     = aux_clk_pkg::CG_OFF;
                            n.clk    = 1'b0;
                            n.stop_p = 1'b1;
                        end else if (stop_req) begin
                            // (RL6) tail of extra cycles on sleep entry
                            n.st   = aux_clk_pkg::CG_TAIL;
                            n.tail = tail_len(tail_code);
                        end else begin
                            // (RL3) selected division or 32.768 kHz
                            n.st  = aux_clk_pkg::CG_RUN;
                            n.lf  = want_lf || sel == `SEL_LF;
                            n.sel = want_lf ? `SEL_LF : sel;
                        end
                    end else begin
                        n.pos = s.pos + 6'h01;
                        n.clk = (s.pos + 6'h01) < high;
                    end
                end
            end
        endcase
        // (RL7) crystal runs unless really asleep
        n.xen = ~sleep_eff | (n.st != aux_clk_pkg::CG_OFF && !n.lf);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s <= '{st: aux_clk_pkg::CG_RUN, pos: 6'h00, tail: `TAIL_0, sel: 3'(`RST_OCLK), lf: 1'b0,
                   clk: 1'b1, xen: 1'b1, stop_p: 1'b0};
        end else begin
            s <= n;
        end
    end

    assign clk_out     = s.clk;
    assign xtal_enable = s.xen;
    assign stop_pulse  = s.stop_p;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    stop_is_low_a: assert property (stop_pulse |-> !clk_out && s.st == aux_clk_pkg::CG_OFF) // RL19
        else $error("clock stopped while high");
    no_tick_hold_a: assert property (s.st != aux_clk_pkg::CG_OFF && !tick |=> $stable(clk_out)) // RL19
        else $error("output clock moved without a source edge");
    lf_in_sleep_a: assert property (s.st == aux_clk_pkg::CG_RUN && want_lf && !s.lf && tick
                                    && s.pos == period - 6'h01 |=> s.lf && s.sel == `SEL_LF) // RL5
        else $error("low-frequency substitute not taken at boundary");

endmodule : clkout_gen

// ---- verilog/radio_aux_clkout_adc_ctrl.sv ----
// register file, converter handshake, reset outputs and interrupt of the
// auxiliary clock-output / converter controller, with the output clock generator
// assumes an Avalon-MM master, edge pulses and radio mode levels synchronous to clock
//
// How it works
// (RL1) every reset loads all control registers with their defaults
// (RL2) pin 0 shows reset, pin 1 shows inverted reset
// (RL3) select codes give 30,15,10,4,3,2,1 MHz and 32.768 kHz
// (RL4) output clock control resets to 06h: 1 MHz on pin 2
// (RL5) sleep with substitute enabled outputs 32.768 kHz; other modes the selection
// (RL6) substitute off: sleep stops the clock after 0/128/256/512 tail cycles
// (RL7) pending interrupt keeps clock and crystal running until status is read
// (RL8) writing start bit begins conversion; bit reads 0 busy, 1 done
// (RL9) conversion finishes and done rises 350 us after the start write
// (RL10) 8-bit result lands in read-only register; host reads after done
// (RL11) configuration: input 6:4, reference 3:2, gain 1:0
// (RL12) bandgap reference gives 4 mV steps over 0 to 1.02 V
// (RL13) low nibble of sensor offset register selects bridge offset voltage
// (RL14) sensor powered when selected as input or routed to test bus
// (RL15) range code selects one of four temperature spans and step sizes
// (RL16) host sequence: input 000, reference 00, range, offset enable, start, read
// (RL17) offset enable adds the offset register to the result digitally
// (RL18) after reset pin 2 is clock, pin 0 reset, pin 1 inverted reset
// (RL19) clock source changes and stops never truncate a pulse
`timescale 1ns/100ps
`include "aux_clk_consts.svh"

module radio_aux_clkout_adc_ctrl #(
    parameter int unsigned CONV_CYCLES = (`ADC_CONV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire logic                      clock,
    input  wire logic                      resetn,
    input  wire logic [7:0]                address,
    input  wire logic                      read,
    input  wire logic                      write,
    input  wire logic [3:0]                byteenable,
    input  wire logic [31:0]               writedata,
    output logic      [31:0]               readdata,
    output logic                           waitrequest,
    input  wire logic                      xtal_edge,
    input  wire logic                      lf_edge,
    input  wire logic                      sleep_cmd,
    input  wire logic                      irq_pending,
    input  wire logic                      atb_temp_sel,
    input  wire logic [7:0]                adc_sample,
    output logic                           gpio0_out,
    output logic                           gpio1_out,
    output logic                           gpio2_out,
    output logic                           xtal_enable,
    output aux_clk_pkg::analog_ctrl_s      analog_ctrl,
    output logic                           irq
);

    localparam logic [19:0] CONV_LAST = 20'(CONV_CYCLES - 1);

    aux_clk_pkg::ctrl_state_s s, n;

    logic sleep_eff;
    logic stop_pulse;

    //--------------------------------------------------------------
    // decode helpers
    //--------------------------------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction : hit

    function automatic logic [7:0] rd_mux(input aux_clk_pkg::ctrl_state_s st, input logic [7:0] addr);
        logic [7:0] d;
        d = 8'h00;
        if (hit(addr, `REG_OCLK))   d = st.oclk;
        // (RL8) start bit reads back the done state
        if (hit(addr, `REG_ADCCFG)) d = {st.done, st.adccfg};
        if (hit(addr, `REG_SOFFS))  d = st.soffs;
        if (hit(addr, `REG_RESULT)) d = st.result;
        if (hit(addr, `REG_TSCTL))  d = st.tsctl;
        if (hit(addr, `REG_TVOFFS)) d = st.tvoffs;
        if (hit(addr, `REG_STATUS)) d = st.status;
        if (hit(addr, `REG_MASK))   d = st.mask;
        return d;
    endfunction : rd_mux

    //--------------------------------------------------------------
    // output clock generator
    //--------------------------------------------------------------
    // (RL7) a pending interrupt overrides a sleep command
    assign sleep_eff = sleep_cmd & ~irq_pending;

    clkout_gen u_clkout (
        .clock       (clock),
        .resetn      (resetn),
        .xtal_edge   (xtal_edge),
        .lf_edge     (lf_edge),
        .sel         (s.oclk[`OCLK_SEL]),
        .enlfc       (s.oclk[`OCLK_ENLF]),
        .tail_code   (s.oclk[`OCLK_TAIL]),
        .sleep_eff   (sleep_eff),
        .clk_out     (gpio2_out),
        .xtal_enable (xtal_enable),
        .stop_pulse  (stop_pulse)
    );

    //--------------------------------------------------------------
    // next state
    //--------------------------------------------------------------
    logic       acc;
    logic       wr_go;
    logic       rd_go;
    logic       start;
    logic [7:0] ev;
    logic [7:0] clr;
    logic [7:0] wd;

    always_comb begin
        n     = s;
        ev    = 8'h00;
        clr   = 8'h00;
        wd    = writedata[7:0];
        // first cycle of a request raises the answer, second completes it
        acc   = (read | write) & s.wreq;
        rd_go = read & ~s.wreq;
        wr_go = write & ~s.wreq & byteenable[0];
        start = wr_go && hit(address, `REG_ADCCFG) && wd[`ADC_START];
        n.wreq = ~acc;
        if (acc && read) begin
            n.rdata = {24'h000000, rd_mux(s, address)};
        end

        // (RL10) result register has no write path
        if (wr_go) begin
            if (hit(address, `REG_OCLK))   n.oclk   = wd & `OCLK_USED;
            // (RL11) input, reference and gain fields
            if (hit(address, `REG_ADCCFG)) n.adccfg = wd[6:0];
            // (RL13) sensor offset nibble
            if (hit(address, `REG_SOFFS))  n.soffs  = wd & `SOFFS_USED;
            if (hit(address, `REG_TSCTL))  n.tsctl  = wd;
            if (hit(address, `REG_TVOFFS)) n.tvoffs = wd;
            if (hit(address, `REG_MASK))   n.mask   = wd & `ST_USED;
        end

        // (RL9) fixed conversion time from the start write
        if (s.busy) begin
            if (s.conv_cnt == CONV_LAST) begin
                n.busy = 1'b0;
                n.done = 1'b1;
                // (RL17) digital offset added when enabled
                n.result = s.tsctl[`TS_OFFS_EN] ? 8'(adc_sample + s.tvoffs) : adc_sample;
                ev[`ST_ADC_DONE] = 1'b1;
            end else begin
                n.conv_cnt = s.conv_cnt + 20'h00001;
            end
        end
        // (RL8) start write clears done and restarts the count
        if (start) begin
            n.busy     = 1'b1;
            n.done     = 1'b0;
            n.conv_cnt = 20'h00000;
        end

        if (stop_pulse) ev[`ST_CLK_STOP] = 1'b1;
        // only bits already reported are cleared, a new event wins
        if (rd_go && hit(address, `REG_STATUS)) clr = s.rdata[7:0];
        n.status = (s.status & ~clr) | ev;
        n.irq    = |(n.status & n.mask);

        // (RL2) reset indication leaves its asserted level after release
        n.por   = 1'b0;
        n.por_n = 1'b1;
        // (RL14) sensor power follows input select or test bus
        n.spwr  = (n.adccfg[`ADC_INSEL] == `INSEL_TEMP) | atb_temp_sel;
    end

    //--------------------------------------------------------------
    // state register
    //--------------------------------------------------------------
    // (RL1) all registers return to defaults on every reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            // (RL4) output clock control comes up 1 MHz, no substitute, no tail
            // (RL18) pins 0/1 show reset, pin 2 runs the clock
            s <= '{oclk: `RST_OCLK, adccfg: 7'(`RST_ADCCFG), soffs: `RST_SOFFS, tsctl: `RST_TSCTL,
                   tvoffs: `RST_TVOFFS, result: `RST_RESULT, status: 8'h00, mask: `RST_MASK,
                   done: 1'b0, busy: 1'b0, conv_cnt: 20'h00000, wreq: 1'b1, rdata: 32'h00000000,
                   irq: 1'b0, por: 1'b1, por_n: 1'b0, spwr: 1'b1};
        end else begin
            s <= n;
        end
    end

    //--------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------
    assign readdata    = s.rdata;
    assign waitrequest = s.wreq;
    assign gpio0_out   = s.por;
    assign gpio1_out   = s.por_n;
    assign irq         = s.irq;
    // (RL12) reference select steers the step size in the converter
    // (RL15) range code passed to the sensor
    assign analog_ctrl = '{input_sel: s.adccfg[`ADC_INSEL], ref_sel: s.adccfg[`ADC_REF],
                           gain: s.adccfg[`ADC_GAIN], sensor_offset: s.soffs[3:0],
                           temp_range: s.tsctl[`TS_RANGE], temp_offs_en: s.tsctl[`TS_OFFS_EN],
                           temp_trim_en: s.tsctl[`TS_TRIM_EN], temp_trim: s.tsctl[`TS_TRIM],
                           bg_trim: s.tsctl[`TS_BG_TRIM], sensor_power: s.spwr};

    //--------------------------------------------------------------
    // checks
    //--------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence start_wr;
        write && !waitrequest && byteenable[0] && address == `REG_ADCCFG && writedata[`ADC_START];
    endsequence
    sequence conv_run;
        s.busy && !s.done;
    endsequence

    bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest) // RL1
        else $error("bus answer not one cycle after request");
    adc_start_a: assert property (start_wr |=> conv_run) // RL8
        else $error("start write did not begin conversion");
    adc_time_a: assert property ($rose(s.done) |-> $past(s.conv_cnt) == CONV_LAST && !s.busy) // RL9
        else $error("done raised at wrong count");
    done_read_a: assert property (read && waitrequest && address == `REG_ADCCFG
                                  |=> readdata[`ADC_START] == $past(s.done)) // RL8
        else $error("start bit does not read done state");
    result_offs_a: assert property ($rose(s.done) && s.tsctl[`TS_OFFS_EN]
                                    |-> s.result == 8'($past(adc_sample) + s.tvoffs)) // RL17
        else $error("result offset wrong");
    reset_pins_a: assert property (gpio1_out == !gpio0_out) // RL2
        else $error("pin 1 not inverted reset");
    sensor_pwr_a: assert property (##1 s.spwr == ($past(n.adccfg[`ADC_INSEL]) == `INSEL_TEMP
                                                  || $past(atb_temp_sel))) // RL14
        else $error("sensor power wrong");
    irq_hold_a: assert property (irq_pending |=> xtal_enable) // RL7
        else $error("crystal stopped with interrupt pending");
    done_flag_a: assert property ($rose(s.done) |=> s.status[`ST_ADC_DONE]) // RL10
        else $error("done event not flagged");

endmodule : radio_aux_clkout_adc_ctrl

// ---- sim/edge_source.sv ----
// oscillator pulse source for the bench: crystal and low-frequency edges
// assumes the bench clock; pulses change just after rising edges
`timescale 1ns/100ps

module edge_source #(
    parameter int XD  = 2,
    parameter int LFD = 10
) (
    input  wire logic clock,
    output logic      xtal_edge,
    output logic      lf_edge
);
    int xc = 0;
    int lc = 0;
    initial begin
        xtal_edge = 1'b0;
        lf_edge = 1'b0;
    end
    always @(posedge clock) begin
        xc <= (xc + 1) % XD;
        lc <= (lc + 1) % LFD;
        xtal_edge <= (xc == 0);
        lf_edge <= (lc == 0);
    end
endmodule : edge_source

// ---- sim/radio_aux_clkout_adc_ctrl_tb.sv ----
// self-checking bench of the clock-output / converter controller
// assumes edge_source supplies oscillator pulses; the bench acts as host
`timescale 1ns/100ps
`include "aux_clk_consts.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("Error %s exp %h got %h", n, e, g); end end

module radio_aux_clkout_adc_ctrl_tb;
    localparam int XD = 2;
    localparam int LFD = 10;
    localparam int HALF [8] = '{2, 4, 6, 15, 20, 30, 60, 2};
    localparam logic [7:0] RA [6] = '{`REG_OCLK, `REG_ADCCFG, `REG_SOFFS, `REG_TSCTL, `REG_TVOFFS, `REG_RESULT};
    localparam logic [7:0] RV [6] = '{8'h06, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
    logic clock = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0;
    logic sleep_cmd = 1'b0, irq_pending = 1'b0, atb_temp_sel = 1'b0;
    logic [7:0] address = 8'h00, adc_sample = 8'h00, q, d, t;
    logic [31:0] writedata = 32'h0, readdata;
    logic waitrequest, xtal_edge, lf_edge, gpio0_out, gpio1_out, gpio2_out, xtal_enable, irq;
    aux_clk_pkg::analog_ctrl_s analog_ctrl;
    int fails = 0, checked = 0, cyc = 0, r, k;
    int seed = 32'hedf4;

    edge_source #(.XD(XD), .LFD(LFD)) i_osc (.clock(clock), .xtal_edge(xtal_edge), .lf_edge(lf_edge));
    radio_aux_clkout_adc_ctrl #(.CONV_CYCLES(20)) i_dut (
        .clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
        .byteenable(4'h1), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .xtal_edge(xtal_edge), .lf_edge(lf_edge), .sleep_cmd(sleep_cmd), .irq_pending(irq_pending),
        .atb_temp_sel(atb_temp_sel), .adc_sample(adc_sample), .gpio0_out(gpio0_out),
        .gpio1_out(gpio1_out), .gpio2_out(gpio2_out), .xtal_enable(xtal_enable),
        .analog_ctrl(analog_ctrl), .irq(irq));

    always #4 clock = ~clock;

    task automatic complete_run();
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            complete_run();
        end
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        address <= a;
        read <= !w;
        write <= w;
        writedata <= {24'h000000, v};
        // hold the request until waitrequest is seen low at a rising edge
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic rises(input int n);
        logic pv;
        r = 0;
        pv = gpio2_out;
        repeat (n) begin
            @(negedge clock);
            if (pv === 1'b0 && gpio2_out === 1'b1) r++;
            pv = gpio2_out;
        end
        @(posedge clock);
    endtask : rises

    // rise-to-rise distance in clock cycles, left in k
    task automatic period();
        logic pv;
        k = 0;
        r = 0;
        pv = gpio2_out;
        while (r < 2 && k < 3000) begin
            @(negedge clock);
            k++;
            if (pv === 1'b0 && gpio2_out === 1'b1) begin
                r++;
                if (r == 1) k = 0;
            end
            pv = gpio2_out;
        end
        @(posedge clock);
    endtask : period

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (12) @(posedge clock);
        `CHK("gpio0 in reset", 1'b1, gpio0_out)
        resetn <= 1'b1;
        @(posedge clock);
        @(negedge clock);
        `CHK("gpio0", 1'b0, gpio0_out)
        `CHK("gpio1", 1'b1, gpio1_out)
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, RA[i], 8'h00);
            `CHK("reset value", RV[i], q)
        end
        period();
        `CHK("default period", 60 * XD, k)
    endtask : do_reset

    initial begin
        do_reset();
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, `REG_OCLK, 8'(s));
            period();
            period();
            `CHK("clock period", HALF[s] * (s == 7 ? LFD : XD), k)
        end
        bus(1'b1, `REG_OCLK, 8'h08);
        sleep_cmd <= 1'b1;
        period();
        period();
        `CHK("sleep period", 2 * LFD, k)
        sleep_cmd <= 1'b0;
        period();
        period();
        `CHK("awake period", 2 * XD, k)
        bus(1'b1, `REG_OCLK, 8'h00);
        bus(1'b1, `REG_MASK, 8'h02);
        irq_pending <= 1'b1;
        sleep_cmd <= 1'b1;
        rises(100);
        `CHK("held clock", 1'b1, r > 20)
        `CHK("held crystal", 1'b1, xtal_enable)
        irq_pending <= 1'b0;
        rises(50);
        rises(200);
        `CHK("stopped clock", 0, r)
        `CHK("crystal off", 1'b0, xtal_enable)
        `CHK("stop irq", 1'b1, irq)
        bus(1'b0, `REG_STATUS, 8'h00);
        `CHK("stop status", 8'h02, q)
        @(negedge clock);
        `CHK("irq cleared", 1'b0, irq)
        @(posedge clock);
        sleep_cmd <= 1'b0;
        bus(1'b1, `REG_OCLK, 8'h10);
        period();
        sleep_cmd <= 1'b1;
        rises(1000);
        `CHK("tail cycles", 1'b1, r inside {128, 129})
        sleep_cmd <= 1'b0;
        bus(1'b0, `REG_STATUS, 8'h00);
        bus(1'b1, `REG_MASK, 8'h01);
        t = 8'($random(seed));
        bus(1'b1, `REG_TVOFFS, t);
        bus(1'b1, `REG_TSCTL, 8'h20);
        d = 8'($random(seed));
        adc_sample <= d;
        bus(1'b1, `REG_ADCCFG, 8'h80);
        k = 0;
        while (irq !== 1'b1 && k < 100) begin
            @(negedge clock);
            k++;
        end
        `CHK("conversion time", 1'b1, k inside {20, 21})
        bus(1'b0, `REG_ADCCFG, 8'h00);
        `CHK("done bit", 8'h80, q)
        bus(1'b1, `REG_RESULT, ~(d + t));
        bus(1'b0, `REG_RESULT, 8'h00);
        `CHK("offset result", d + t, q)
        bus(1'b0, `REG_STATUS, 8'h00);
        `CHK("done status", 8'h01, q)
        bus(1'b0, `REG_STATUS, 8'h00);
        `CHK("status cleared", 8'h00, q)
        bus(1'b1, `REG_MASK, 8'h00);
        bus(1'b1, `REG_TSCTL, 8'h00);
        d = 8'($random(seed));
        adc_sample <= d;
        bus(1'b1, `REG_ADCCFG, 8'h80);
        bus(1'b0, `REG_ADCCFG, 8'h00);
        `CHK("busy bit", 8'h00, q)
        repeat (24) @(negedge clock);
        `CHK("masked irq", 1'b0, irq)
        bus(1'b0, `REG_RESULT, 8'h00);
        `CHK("plain result", d, q)
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 8'h0c : 8'($random(seed)) & 8'h7f;
            atb_temp_sel <= (i % 2 == 1);
            bus(1'b1, `REG_ADCCFG, d);
            bus(1'b1, `REG_SOFFS, {4'h0, d[3:0]});
            bus(1'b1, `REG_TSCTL, {d[1:0], 6'h20});
            bus(1'b0, `REG_ADCCFG, 8'h00);
            `CHK("config", d[6:0], q[6:0])
            `CHK("fields", {d[6:0], d[3:0], d[1:0], 1'b1}, analog_ctrl[19:6])
            `CHK("sensor power", d[6:4] == 3'h0 || i % 2 == 1, analog_ctrl.sensor_power)
        end
        do_reset();
        complete_run();
    end
endmodule : radio_aux_clkout_adc_ctrl_tb
